// ===== hdl/pmc_pkg.sv
package pmc_pkg;
  // Clock and time base
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
  // Power mode timing in milliseconds
  localparam int ACK_DEADLINE_MS = 128;
  localparam int RESET_GAP_MS = 2;
  localparam int DEGLITCH_MS = 32;
  // Serial link rate and quarter bit time, rounded up
  localparam int I2C_RATE_KBPS = 400;
  localparam int I2C_BIT_NS = 1000000 / I2C_RATE_KBPS;
  localparam int I2C_QTR_CYC = (I2C_BIT_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  // Slave address and device registers
  localparam logic [6:0] SLAVE_ADDR = 7'h60;
  localparam logic [7:0] REG_PON = 8'h00;
  localparam logic [7:0] REG_REGEN = 8'h02;
  localparam int PON_ACK_BIT = 4;
  localparam int PON_SRC_USB = 0;
  localparam int PON_SRC_ADAPTER = 1;
  localparam int PON_SRC_BUTTON = 2;
  localparam int PON_SRC_BATTERY = 3;
  localparam int NUM_SUPPLIES = 5;
  localparam int CORE_BUCK_IDX = 0;
  localparam logic [4:0] REGEN_RESET = 5'h1f;
  // Host controller registers (byte addresses)
  localparam logic [3:0] HOST_CMD = 4'h0;
  localparam logic [3:0] HOST_STATUS = 4'h4;
  localparam logic [3:0] HOST_RDATA = 4'h8;
  localparam logic [3:0] HOST_CTRL = 4'hc;
  localparam int CMD_READ_BIT = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam int STAT_BUTTON_BIT = 2;
  localparam int CTRL_ACK_PIN_BIT = 0;
  // Host byte phases
  localparam logic [2:0] PH_ADDR_WR = 3'h0;
  localparam logic [2:0] PH_REG = 3'h1;
  localparam logic [2:0] PH_DATA = 3'h2;
  localparam logic [2:0] PH_ADDR_RD = 3'h3;
  localparam logic [2:0] PH_READ = 3'h4;

  typedef enum logic [1:0] {PM_STANDBY, PM_ACTIVE, PM_RESET_GAP, PM_CHG_STANDBY} pmc_mode_e;
  typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_REG, SL_DATA, SL_READ, SL_IGNORE} pmc_slave_e;
  typedef enum logic [1:0] {HM_IDLE, HM_START, HM_BYTE, HM_STOP} pmc_master_e;
endpackage

// ===== hdl/pmc_if.sv
`timescale 1ns/1ps
interface pmc_if;
  logic scl_out;
  logic scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic power_ack_pin;
  logic button_status;
  logic scl;
  logic sda;

  // Open-drain wires with pull-ups
  assign scl = !(scl_oe && !scl_out);
  assign sda = !((host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out));

  modport dev(input scl, input sda, input power_ack_pin, output dev_sda_out, output dev_sda_oe, output button_status);
  modport host(input scl, input sda, input button_status, output scl_out, output scl_oe, output host_sda_out,
               output host_sda_oe, output power_ack_pin);
endinterface

// ===== hdl/pmc_i2c_slave.sv
`timescale 1ns/1ps
module pmc_i2c_slave
  import pmc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic en_in,
  // Synchronised link lines
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_out,
  // Register access
  output logic wr_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  input wire logic [7:0] rdata_in
);
  pmc_slave_e state_q;
  logic scl_d_q;
  logic sda_d_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic nack_q;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  always_ff @(posedge clk_in) begin
    scl_d_q <= scl_in;
    sda_d_q <= sda_in;
  end

  // Edges found by sampling SCL on the system clock
  assign rise = scl_in && !scl_d_q;
  assign fall = !scl_in && scl_d_q;
  assign start = scl_in && scl_d_q && sda_d_q && !sda_in;
  assign stop = scl_in && scl_d_q && !sda_d_q && sda_in;

  always_ff @(posedge clk_in) begin
    if (rst_in || !en_in) begin
      state_q <= SL_IDLE;
      cnt_q <= 4'h0;
      sda_oe_out <= 1'b0;
      wr_out <= 1'b0;
      addr_out <= 8'h00;
      wdata_out <= 8'h00;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      nack_q <= 1'b0;
    end else begin
      wr_out <= 1'b0;
      if (start) begin
        state_q <= SL_ADDR;
        // The SCL fall that closes START wraps the count to zero
        cnt_q <= 4'hf;
        sda_oe_out <= 1'b0;
      end else if (stop) begin
        state_q <= SL_IDLE;
        sda_oe_out <= 1'b0;
      end else if (rise && cnt_q < 4'h8) begin
        sh_q <= {sh_q[6:0], sda_in};
      end else if (rise) begin
        nack_q <= sda_in;
      end else if (fall && state_q != SL_IDLE && state_q != SL_IGNORE) begin
        if (cnt_q == 4'h7) begin
          cnt_q <= 4'h8;
          case (state_q)
            SL_ADDR: begin
              if (sh_q[7:1] == SLAVE_ADDR) begin
                sda_oe_out <= 1'b1;
              end else begin
                state_q <= SL_IGNORE;
              end
            end
            SL_REG: begin
              addr_out <= sh_q;
              sda_oe_out <= 1'b1;
            end
            SL_DATA: begin
              wdata_out <= sh_q;
              wr_out <= 1'b1;
              sda_oe_out <= 1'b1;
            end
            default: sda_oe_out <= 1'b0;
          endcase
        end else if (cnt_q == 4'h8) begin
          cnt_q <= 4'h0;
          sda_oe_out <= 1'b0;
          case (state_q)
            SL_ADDR: begin
              if (sh_q[0]) begin
                state_q <= SL_READ;
                tx_q <= rdata_in;
                sda_oe_out <= !rdata_in[7];
              end else begin
                state_q <= SL_REG;
              end
            end
            SL_REG: state_q <= SL_DATA;
            SL_DATA: state_q <= SL_REG;
            SL_READ: begin
              if (nack_q) begin
                state_q <= SL_IGNORE;
              end else begin
                tx_q <= rdata_in;
                sda_oe_out <= !rdata_in[7];
              end
            end
            default: state_q <= SL_IGNORE;
          endcase
        end else begin
          cnt_q <= cnt_q + 4'h1;
          if (state_q == SL_READ) begin
            tx_q <= {tx_q[6:0], 1'b0};
            sda_oe_out <= !tx_q[6];
          end
        end
      end
    end
  end
endmodule

// ===== hdl/pmc_device.sv
// What this block does
// - Button press while active only toggles status
// - Processor clears ack bit and pin
// - External supply present keeps device active
// - Software switches supplies except core buck
// - Supply removal: stay active unless low/unacked
// - Missed 128 ms ack asserts reset
// - Wait 2 ms, then supplies off
// - Standby left only on power-on event
// - Missed ack with charger enters charger standby
// - Charger standby: defaults, regulators, serial off
// - Charger standby: button to active, unplug standby
// - Serial slave timed only by SCL
// - SDA changes only while SCL low
// - Master makes START and STOP
// - Repeated START equals first START
// - Eight bits MSB first, ninth acknowledge
// - Addressed slave acknowledges every byte
// - Address byte carries direction bit
// - Fixed slave address 60h
// - Register read preceded by address write
// - Endless register address and data pairs
//
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module pmc_device
  import pmc_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Link to processor
  pmc_if.dev link,
  // Supplies and button
  input wire logic button_in,
  input wire logic adapter_supply_in,
  input wire logic usb_supply_in,
  input wire logic batt_low_in,
  // Power outputs
  output logic [NUM_SUPPLIES-1:0] supply_en_out,
  output logic system_reset_n_out,
  output logic charger_on_out,
  output logic charger_defaults_out,
  output logic [1:0] mode_out
);
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  logic btn_s;
  logic adp_s;
  logic usb_s;
  logic low_s;
  logic scl_s;
  logic sda_s;
  logic ackpin_s;
  logic [$clog2(MS_CYCLES)-1:0] ms_cnt_q;
  logic ms_tick_q;
  logic [5:0] dg_cnt_q;
  logic btn_q;
  logic btn_prev_q;
  logic adp_prev_q;
  logic usb_ok_prev_q;
  pmc_mode_e mode_q;
  logic [7:0] tm_q;
  logic [$clog2(MS_CYCLES)-1:0] ph_q;
  logic acked_q;
  logic to_chg_q;
  logic power_ack_bit_q;
  logic [3:0] src_q;
  logic [NUM_SUPPLIES-1:0] regen_q;
  logic ext;
  logic ack_now;
  logic usb_ok;
  logic [3:0] pon_ev;
  logic wr;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic sda_oe;

  // Two-stage synchronisers for every outside input
  always_ff @(posedge clk_in) begin
    meta_q <= {link.power_ack_pin, link.sda, link.scl, batt_low_in, usb_supply_in, adapter_supply_in, button_in};
    sync_q <= meta_q;
  end
  assign {ackpin_s, sda_s, scl_s, low_s, usb_s, adp_s, btn_s} = sync_q;

  // Millisecond tick
  always_ff @(posedge clk_in) begin
    if (rst_in || ms_tick_q) begin
      ms_cnt_q <= '0;
      ms_tick_q <= 1'b0;
    end else begin
      ms_cnt_q <= ms_cnt_q + 1'b1;
      ms_tick_q <= (ms_cnt_q == ($clog2(MS_CYCLES))'(MS_CYCLES - 2));
    end
  end

  // Button deglitch, shown on the status line
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dg_cnt_q <= 6'h00;
      btn_q <= 1'b0;
    end else if (btn_s == btn_q) begin
      dg_cnt_q <= 6'h00;
    end else if (ms_tick_q) begin
      if (dg_cnt_q == 6'(DEGLITCH_MS - 1)) begin
        btn_q <= btn_s;
        dg_cnt_q <= 6'h00;
      end else begin
        dg_cnt_q <= dg_cnt_q + 6'h01;
      end
    end
  end
  assign link.button_status = btn_q;

  // Power-on events
  assign ext = adp_s || usb_s;
  assign usb_ok = usb_s && !low_s;
  assign ack_now = power_ack_bit_q || ackpin_s;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      btn_prev_q <= 1'b0;
      adp_prev_q <= 1'b0;
      usb_ok_prev_q <= 1'b0;
    end else begin
      btn_prev_q <= btn_q;
      adp_prev_q <= adp_s;
      usb_ok_prev_q <= usb_ok;
    end
  end
  always_comb begin
    pon_ev = 4'h0;
    pon_ev[PON_SRC_USB] = usb_ok && !usb_ok_prev_q;
    pon_ev[PON_SRC_ADAPTER] = adp_s && !adp_prev_q;
    pon_ev[PON_SRC_BUTTON] = btn_q && !btn_prev_q;
  end

  // Power mode sequencing
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_q <= PM_STANDBY;
      {tm_q, ph_q} <= '0;
      acked_q <= 1'b0;
      to_chg_q <= 1'b0;
      src_q <= 4'h0;
      src_q[PON_SRC_BATTERY] <= 1'b1;
    end else begin
      // Mode timer counts whole milliseconds from entry into active or the reset gap
      ph_q <= (ph_q == ($clog2(MS_CYCLES))'(MS_CYCLES - 1)) ? '0 : ph_q + 1'b1;
      if (ph_q == ($clog2(MS_CYCLES))'(MS_CYCLES - 1) && tm_q != 8'hff) begin
        tm_q <= tm_q + 8'h01;
      end
      case (mode_q)
        PM_STANDBY: begin
          if (pon_ev != 4'h0 && !low_s) begin
            mode_q <= PM_ACTIVE;
            src_q <= pon_ev;
            {tm_q, ph_q} <= '0;
            acked_q <= 1'b0;
          end
        end
        PM_CHG_STANDBY: begin
          if (!ext) begin
            mode_q <= PM_STANDBY;
          end else if (pon_ev[PON_SRC_BUTTON]) begin
            mode_q <= PM_ACTIVE;
            src_q <= pon_ev;
            {tm_q, ph_q} <= '0;
            acked_q <= 1'b0;
          end
        end
        PM_ACTIVE: begin
          if (!acked_q) begin
            if (ack_now) begin
              acked_q <= 1'b1;
            end else if (tm_q >= 8'(ACK_DEADLINE_MS)) begin
              mode_q <= PM_RESET_GAP;
              to_chg_q <= ext;
              {tm_q, ph_q} <= '0;
            end
          end else if (!ext && (!ack_now || low_s)) begin
            mode_q <= PM_RESET_GAP;
            to_chg_q <= 1'b0;
            {tm_q, ph_q} <= '0;
          end
        end
        PM_RESET_GAP: begin
          if (tm_q >= 8'(RESET_GAP_MS)) begin
            mode_q <= to_chg_q ? PM_CHG_STANDBY : PM_STANDBY;
            src_q <= 4'h0;
          end
        end
        default: mode_q <= PM_STANDBY;
      endcase
    end
  end

  // Register file written by the serial slave
  always_ff @(posedge clk_in) begin
    if (rst_in || mode_q == PM_STANDBY || mode_q == PM_CHG_STANDBY) begin
      power_ack_bit_q <= 1'b0;
      regen_q <= REGEN_RESET;
    end else if (wr && waddr == REG_PON) begin
      power_ack_bit_q <= wdata[PON_ACK_BIT];
    end else if (wr && waddr == REG_REGEN) begin
      regen_q <= wdata[NUM_SUPPLIES-1:0];
    end
  end
  always_comb begin
    rdata = 8'h00;
    if (waddr == REG_PON) begin
      rdata[3:0] = src_q;
      rdata[PON_ACK_BIT] = power_ack_bit_q;
    end else if (waddr == REG_REGEN) begin
      rdata[NUM_SUPPLIES-1:0] = regen_q;
    end
  end

  // Serial slave, disabled outside active modes
  pmc_i2c_slave u_slave (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .en_in(mode_q == PM_ACTIVE || mode_q == PM_RESET_GAP),
    .scl_in(scl_s),
    .sda_in(sda_s),
    .sda_oe_out(sda_oe),
    .wr_out(wr),
    .addr_out(waddr),
    .wdata_out(wdata),
    .rdata_in(rdata)
  );
  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe = sda_oe;

  // Output drivers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      supply_en_out <= '0;
      system_reset_n_out <= 1'b0;
      charger_on_out <= 1'b0;
      charger_defaults_out <= 1'b0;
      mode_out <= 2'h0;
    end else begin
      supply_en_out <= '0;
      if (mode_q == PM_ACTIVE || mode_q == PM_RESET_GAP) begin
        supply_en_out <= regen_q;
        supply_en_out[CORE_BUCK_IDX] <= 1'b1;
      end
      system_reset_n_out <= (mode_q == PM_ACTIVE);
      charger_on_out <= ext && mode_q != PM_STANDBY;
      charger_defaults_out <= (mode_q == PM_CHG_STANDBY);
      mode_out <= mode_q;
    end
  end
endmodule

// ===== hdl/pmc_host.sv
`timescale 1ns/1ps
module pmc_host
  import pmc_pkg::*;
#(
  parameter int QTR_CYCLES = I2C_QTR_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Link to device
  pmc_if.host link
);
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic ack_q;
  pmc_master_e st_q;
  logic [$clog2(QTR_CYCLES+1)-1:0] div_q;
  logic tick_q;
  logic [1:0] qq_q;
  logic [3:0] bit_q;
  logic [2:0] ph_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic [7:0] rdata_q;
  logic [7:0] reg_q;
  logic [7:0] data_q;
  logic rd_q;
  logic nack_q;
  logic ackpin_q;
  logic [7:0] next_byte;
  logic go;

  always_ff @(posedge clk_in) begin
    meta_q <= {link.button_status, link.sda};
    sync_q <= meta_q;
  end

  // One-wait answer: waitrequest drops one cycle after a request
  assign avs_waitrequest_out = !ack_q;
  assign go = avs_write_in && ack_q && avs_address_in == HOST_CMD && st_q == HM_IDLE;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
      avs_readdata_out <= 32'h0;
      ackpin_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_in || avs_write_in) && !ack_q;
      if (avs_read_in && !ack_q) begin
        avs_readdata_out <= 32'h0;
        case (avs_address_in)
          HOST_STATUS: avs_readdata_out[2:0] <= {sync_q[1], nack_q, st_q != HM_IDLE};
          HOST_RDATA: avs_readdata_out[7:0] <= rdata_q;
          HOST_CTRL: avs_readdata_out[CTRL_ACK_PIN_BIT] <= ackpin_q;
          default: avs_readdata_out <= 32'h0;
        endcase
      end
      if (avs_write_in && ack_q && avs_address_in == HOST_CTRL) begin
        ackpin_q <= avs_writedata_in[CTRL_ACK_PIN_BIT];
      end
    end
  end
  assign link.power_ack_pin = ackpin_q;
  assign link.scl_out = 1'b0;
  assign link.host_sda_out = 1'b0;

  // Quarter bit tick
  always_ff @(posedge clk_in) begin
    if (rst_in || st_q == HM_IDLE || tick_q) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_q + 1'b1;
      tick_q <= (div_q == ($clog2(QTR_CYCLES+1))'(QTR_CYCLES - 2));
    end
  end

  always_comb begin
    case (ph_q)
      PH_ADDR_WR: next_byte = {SLAVE_ADDR, 1'b0};
      PH_REG: next_byte = reg_q;
      PH_DATA: next_byte = data_q;
      PH_ADDR_RD: next_byte = {SLAVE_ADDR, 1'b1};
      default: next_byte = 8'hff;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q <= HM_IDLE;
      qq_q <= 2'h0;
      bit_q <= 4'h0;
      ph_q <= PH_ADDR_WR;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      rdata_q <= 8'h00;
      reg_q <= 8'h00;
      data_q <= 8'h00;
      rd_q <= 1'b0;
      nack_q <= 1'b0;
      link.scl_oe <= 1'b0;
      link.host_sda_oe <= 1'b0;
    end else if (go) begin
      st_q <= HM_START;
      qq_q <= 2'h0;
      ph_q <= PH_ADDR_WR;
      data_q <= avs_writedata_in[7:0];
      reg_q <= avs_writedata_in[15:8];
      rd_q <= avs_writedata_in[CMD_READ_BIT];
      nack_q <= 1'b0;
    end else if (tick_q) begin
      qq_q <= qq_q + 2'h1;
      case (st_q)
        HM_START: begin
          if (qq_q == 2'h0) begin
            link.host_sda_oe <= 1'b0;
            link.scl_oe <= 1'b0;
          end else if (qq_q == 2'h1) begin
            link.host_sda_oe <= 1'b1;
          end else if (qq_q == 2'h2) begin
            link.scl_oe <= 1'b1;
          end else begin
            st_q <= HM_BYTE;
            bit_q <= 4'h0;
            tx_q <= next_byte;
          end
        end
        HM_BYTE: begin
          if (qq_q == 2'h0) begin
            link.host_sda_oe <= bit_q < 4'h8 && ph_q != PH_READ && !tx_q[7];
          end else if (qq_q == 2'h1) begin
            link.scl_oe <= 1'b0;
          end else if (qq_q == 2'h2) begin
            if (bit_q < 4'h8) begin
              rx_q <= {rx_q[6:0], sync_q[0]};
            end else if (ph_q != PH_READ && sync_q[0]) begin
              nack_q <= 1'b1;
            end
          end else begin
            link.scl_oe <= 1'b1;
            if (bit_q < 4'h8) begin
              bit_q <= bit_q + 4'h1;
              tx_q <= {tx_q[6:0], 1'b0};
            end else if (nack_q || ph_q == PH_DATA || ph_q == PH_READ) begin
              st_q <= HM_STOP;
              if (ph_q == PH_READ) begin
                rdata_q <= rx_q;
              end
            end else if (ph_q == PH_REG && rd_q) begin
              st_q <= HM_START;
              ph_q <= PH_ADDR_RD;
            end else begin
              bit_q <= 4'h0;
              ph_q <= ph_q + 3'h1;
              tx_q <= (ph_q == PH_ADDR_RD) ? 8'hff : (ph_q == PH_ADDR_WR ? reg_q : data_q);
            end
          end
        end
        HM_STOP: begin
          if (qq_q == 2'h0) begin
            link.host_sda_oe <= 1'b1;
          end else if (qq_q == 2'h1) begin
            link.scl_oe <= 1'b0;
          end else if (qq_q == 2'h2) begin
            link.host_sda_oe <= 1'b0;
          end else begin
            st_q <= HM_IDLE;
          end
        end
        default: st_q <= HM_IDLE;
      endcase
    end
  end
endmodule

// ===== tb/pmc_monitor.sv
`timescale 1ns/1ps
module pmc_monitor
  import pmc_pkg::*;
#(
  parameter int MS_CYCLES = 50
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Link
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe,
  input wire logic power_ack_pin,
  // Device outputs
  input wire logic [1:0] mode_out,
  input wire logic system_reset_n_out,
  input wire logic [NUM_SUPPLIES-1:0] supply_en_out,
  input wire logic charger_defaults_out
);
  localparam int GAP_LO = RESET_GAP_MS * MS_CYCLES - 2;
  localparam int GAP_HI = RESET_GAP_MS * MS_CYCLES + 2;
  localparam int DEADLINE = ACK_DEADLINE_MS * MS_CYCLES + 8;
  logic scl_q, first_q, mine_q, wr_q, seen_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  int act_q, gap_q;
  wire rise = scl && !scl_q;
  wire ack9 = rise && bit_q == 4'h8 && mode_out == PM_ACTIVE;

  default clocking mon_cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  // Bit counter and byte shifter, restarted by START
  always_ff @(posedge clk_in) begin
    scl_q <= scl;
    if (rst_in || (scl && scl_q && $fell(sda))) begin
      bit_q <= 4'h0;
      first_q <= 1'b1;
    end else if (rise) begin
      sh_q <= {sh_q[6:0], sda};
      bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
      if (bit_q == 4'h8) begin
        first_q <= 1'b0;
        if (first_q) begin
          mine_q <= !sda;
          wr_q <= !sh_q[0];
        end
      end
    end
  end

  // Time spent in active and in the reset gap
  always_ff @(posedge clk_in) begin
    act_q <= (!rst_in && mode_out == PM_ACTIVE) ? act_q + 1 : 0;
    gap_q <= (!rst_in && mode_out == PM_RESET_GAP) ? gap_q + 1 : 0;
    seen_q <= !rst_in && mode_out == PM_ACTIVE && (seen_q || power_ack_pin || (scl && $fell(sda)));
  end

  sda_change_a: assert property (dev_sda_oe != $past(dev_sda_oe) |-> !scl)
    else $error("slave data moved while clock high");
  addr_ack_a: assert property (ack9 && first_q |-> sda == (sh_q[7:1] != SLAVE_ADDR))
    else $error("address acknowledge wrong");
  data_ack_a: assert property (ack9 && !first_q && mine_q && wr_q |-> !sda)
    else $error("written byte not acknowledged");
  leave_active_a: assert property ($fell(mode_out == PM_ACTIVE) |->
    mode_out == PM_RESET_GAP && !system_reset_n_out)
    else $error("active left without reset gap");
  gap_len_a: assert property ($fell(mode_out == PM_RESET_GAP) |-> gap_q >= GAP_LO && gap_q <= GAP_HI)
    else $error("reset gap length wrong");
  deadline_a: assert property (mode_out == PM_ACTIVE && !seen_q |-> act_q <= DEADLINE)
    else $error("acknowledge deadline missed");
  standby_off_a: assert property (mode_out == PM_STANDBY |-> supply_en_out == '0 && !system_reset_n_out)
    else $error("standby with supplies on");
  chg_idle_a: assert property (mode_out == PM_CHG_STANDBY |->
    supply_en_out == '0 && charger_defaults_out && !dev_sda_oe)
    else $error("charger standby not idle");
  core_buck_a: assert property (mode_out inside {PM_ACTIVE, PM_RESET_GAP} |->
    supply_en_out[CORE_BUCK_IDX])
    else $error("core buck off while powered");
endmodule

// ===== tb/pmc_tb.sv
`timescale 1ns/1ps
module pmc_tb;
  import pmc_pkg::*;
  localparam int MS = 50;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdo;
  logic [31:0] rdat;
  logic wq;
  logic btn = 1'b0;
  logic adp = 1'b0;
  logic usb = 1'b0;
  logic blow = 1'b0;
  logic [4:0] sup;
  logic rstn;
  logic dflt;
  logic chg;
  logic [1:0] mode;
  logic [7:0] r;
  int m_ack = 0;
  int m_src = 0;
  int m_regen = 0;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  int n_w;

  pmc_if link ();
  pmc_device #(.MS_CYCLES(MS)) i_pmc_device (.clk_in(clk_in), .rst_in(rst_in), .link(link), .button_in(btn),
    .adapter_supply_in(adp), .usb_supply_in(usb), .batt_low_in(blow), .supply_en_out(sup),
    .system_reset_n_out(rstn), .charger_on_out(chg), .charger_defaults_out(dflt), .mode_out(mode));
  pmc_host #(.QTR_CYCLES(8)) i_pmc_host (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdo), .avs_waitrequest_out(wq), .link(link));
  pmc_monitor #(.MS_CYCLES(MS)) i_pmc_monitor (.clk_in(clk_in), .rst_in(rst_in), .scl(link.scl), .sda(link.sda),
    .dev_sda_oe(link.dev_sda_oe), .power_ack_pin(link.power_ack_pin), .mode_out(mode),
    .system_reset_n_out(rstn), .supply_en_out(sup), .charger_defaults_out(dflt));

  initial begin
    forever #10 clk_in = !clk_in;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fails++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  // One Avalon cycle, held until waitrequest is seen low
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk_in); while (wq !== 1'b0);
    rdat = rdo;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wmode(input logic [1:0] m, input int lim);
    n_w = 0;
    while (mode !== m && n_w < lim) begin
      @(posedge clk_in);
      n_w++;
    end
    chk(mode, m);
  endtask

  // One serial transfer through the host, checked against the model
  task automatic xfer(input logic r_w, input logic [7:0] ra, input logic [7:0] d, input logic ack);
    av(1'b1, HOST_CMD, {15'h0, r_w, ra, d});
    do av(1'b0, HOST_STATUS, 32'h0); while (rdat[STAT_BUSY_BIT] !== 1'b0);
    chk(rdat[STAT_NACK_BIT], !ack);
    if (r_w) begin
      av(1'b0, HOST_RDATA, 32'h0);
      chk(rdat[7:0], m_ack * (1 << PON_ACK_BIT) + m_src);
    end else if (ack && ra == REG_PON) begin
      m_ack = d[PON_ACK_BIT];
    end else if (ack) begin
      m_regen = d[4:0];
    end
  endtask

  initial begin
    void'($urandom(32'haf408804));
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    // Unacknowledged power-up times out into standby
    btn <= 1'b1;
    wmode(PM_ACTIVE, 40 * MS);
    wmode(PM_RESET_GAP, (ACK_DEADLINE_MS + 2) * MS);
    chk(n_w >= ACK_DEADLINE_MS * MS - 8, 1);
    chk(rstn, 0);
    wmode(PM_STANDBY, (RESET_GAP_MS + 1) * MS);
    chk(n_w >= RESET_GAP_MS * MS - 4, 1);
    chk(sup, 0);
    repeat (10 * MS) @(posedge clk_in);
    chk(mode, PM_STANDBY);
    btn <= 1'b0;
    repeat (40 * MS) @(posedge clk_in);
    $display("test 1 done");
    // Acknowledged session with register traffic
    btn <= 1'b1;
    wmode(PM_ACTIVE, 40 * MS);
    m_src = 1 << PON_SRC_BUTTON;
    xfer(1'b0, REG_PON, 8'h10, 1'b1);
    r = 8'($urandom);
    xfer(1'b0, REG_REGEN, {3'h0, r[4:0]}, 1'b1);
    chk(sup, m_regen | (1 << CORE_BUCK_IDX));
    xfer(1'b1, REG_PON, 8'h00, 1'b1);
    btn <= 1'b0;
    repeat (40 * MS) @(posedge clk_in);
    btn <= 1'b1;
    repeat (40 * MS) @(posedge clk_in);
    chk(link.button_status, 1);
    repeat (60 * MS) @(posedge clk_in);
    chk(mode, PM_ACTIVE);
    xfer(1'b0, REG_PON, 8'h00, 1'b1);
    wmode(PM_STANDBY, 5 * MS);
    btn <= 1'b0;
    repeat (40 * MS) @(posedge clk_in);
    $display("test 2 done");
    // External supply keeps the device up
    adp <= 1'b1;
    wmode(PM_ACTIVE, 40 * MS);
    av(1'b1, HOST_CTRL, 32'h1);
    av(1'b1, HOST_CTRL, 32'h0);
    repeat (10 * MS) @(posedge clk_in);
    chk(mode, PM_ACTIVE);
    chk(chg, 1);
    av(1'b1, HOST_CTRL, 32'h1);
    adp <= 1'b0;
    repeat (10 * MS) @(posedge clk_in);
    chk(mode, PM_ACTIVE);
    blow <= 1'b1;
    wmode(PM_STANDBY, 5 * MS);
    blow <= 1'b0;
    av(1'b1, HOST_CTRL, 32'h0);
    $display("test 3 done");
    // Missed deadline with USB present ends in charger standby
    usb <= 1'b1;
    wmode(PM_ACTIVE, 40 * MS);
    wmode(PM_RESET_GAP, (ACK_DEADLINE_MS + 2) * MS);
    wmode(PM_CHG_STANDBY, (RESET_GAP_MS + 1) * MS);
    chk(dflt, 1);
    chk(chg, 1);
    xfer(1'b0, REG_REGEN, 8'h00, 1'b0);
    btn <= 1'b1;
    wmode(PM_ACTIVE, 40 * MS);
    btn <= 1'b0;
    wmode(PM_CHG_STANDBY, (ACK_DEADLINE_MS + RESET_GAP_MS + 5) * MS);
    usb <= 1'b0;
    wmode(PM_STANDBY, 5 * MS);
    $display("test 4 done");
    end_sim();
  end
endmodule
